/* File: hw/psm_pkg.sv */
// Purpose: Shared constants and interface for the peak signal monitor and its link receiver
// Assumes: One clock at the decimated sample rate, synchronous active-high reset
// Notes: Register offsets are byte addresses on the configuration port
//
// Notes on behaviour
// - Track absolute magnitude, keep 13-bit window peak
// - Window length is one global 24-bit count
// - Monitor enable is control register bit 1
// - Host writes window length before enabling
// - Enable loads down-counter, one step per sample
// - Keep larger of sample and stored magnitude
// - Store seeds with current sample, not zero
// - At count one, copy peak to holding register
// - After transfer reload timer and reseed store
// - Results via register readback and link bits
// - Sideband needs 0x279 bits 1:0, 0x27A bit 1
// - Up to three control bits; monitor uses one
// - Control bits fill from MSB; monitor uses the lowest of them
// - Host programs link registers for sideband routing
// - 25-bit frame, MSB first, five 5-bit subframes
// - Each subframe opens with a start bit
// - Receiver extracts and reassembles frames
// - Length bytes at 0x271 (LSB) to 0x273 (MSB)
package psm_pkg;
  localparam int PSM_MAG_W = 13;
  localparam int PSM_PER_W = 24;
  localparam int PSM_SMP_W = 16;
  localparam int PSM_ADDR_W = 12;
  localparam int PSM_CB_MAX = 3;
  localparam int PSM_FRAME_W = 25;
  localparam int PSM_SUB_W = 5;
  localparam int PSM_SUB_N = 5;

  localparam logic [11:0] PSM_REG_CTRL = 12'h270;
  localparam logic [11:0] PSM_REG_PER0 = 12'h271;
  localparam logic [11:0] PSM_REG_PER1 = 12'h272;
  localparam logic [11:0] PSM_REG_PER2 = 12'h273;
  localparam logic [11:0] PSM_REG_HOLD0 = 12'h274;
  localparam logic [11:0] PSM_REG_HOLD1 = 12'h275;
  localparam logic [11:0] PSM_REG_SBA = 12'h279;
  localparam logic [11:0] PSM_REG_SBB = 12'h27a;
  localparam logic [11:0] PSM_REG_LNKA = 12'h559;
  localparam logic [11:0] PSM_REG_LNKB = 12'h55a;
  localparam logic [11:0] PSM_REG_LNKC = 12'h58f;

  localparam int PSM_CTRL_EN_BIT = 1;
  localparam logic [1:0] PSM_SBA_EN = 2'h3;
  localparam int PSM_SBB_EN_BIT = 1;
  localparam logic [1:0] PSM_LNKC_CS_MASK = 2'h3;
  localparam logic [7:0] PSM_RST_BYTE = 8'h00;

  // Subframe heads: start bit then 4-bit tag
  localparam logic [4:0] PSM_SUB_IDENT = 5'h10;
  localparam logic [4:0] PSM_SUB_IDLE = 5'h00;
  localparam logic [0:0] PSM_START_BIT = 1'h1;
  localparam logic [2:0] PSM_FRAME_CNT_LAST = 3'h4;
  localparam logic [2:0] PSM_BIT_CNT_LAST = 3'h4;
  localparam logic [23:0] PSM_CNT_ONE = 24'h000001;

  function automatic logic [12:0] psm_abs(input logic [15:0] s);
    logic [15:0] m;
    m = s[15] ? 16'(-s) : s;
    return (m[15:14] != 2'h0) ? 13'h1fff : m[14:2];
  endfunction
endpackage

/* File: hw/psm_link_if.sv */
`timescale 1ns/1ps
// Purpose: Converter sample link from monitor to receiving logic
// Assumes: Same clock at both ends
// Notes: One sample per clock with its valid strobe
interface psm_link_if;
  logic [15:0] sample;
  logic sample_valid;
  logic [1:0] cb_count;
  modport dev(output sample, output sample_valid, output cb_count);
  modport rcv(input sample, input sample_valid, input cb_count);
endinterface

/* File: hw/psm_monitor.sv */
`timescale 1ns/1ps
// Purpose: Peak magnitude monitor with register access and link sideband
// Assumes: Configuration port is a simple byte read/write strobe port
// Notes: Link sample has sideband control bits overlaid on its high bits
module psm_monitor
  import psm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] SAMPLE,
  input wire logic SAMPLE_VALID,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [11:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  output logic CFG_RVALID,
  output logic [12:0] PEAK_HOLD,
  output logic PEAK_STROBE,
  psm_link_if.dev LINK
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl, per0, per1, per2, sba, sbb, lnka, lnkb, lnkc;
  logic [7:0] next_ctrl, next_per0, next_per1, next_per2, next_sba, next_sbb;
  logic [7:0] next_lnka, next_lnkb, next_lnkc;
  logic [7:0] next_rdata;
  logic next_rvalid;
  logic [12:0] hold, next_hold;
  logic [23:0] window_length;

  assign window_length = {per2, per1, per0};

  always_comb begin
    next_ctrl = ctrl;
    next_per0 = per0;
    next_per1 = per1;
    next_per2 = per2;
    next_sba = sba;
    next_sbb = sbb;
    next_lnka = lnka;
    next_lnkb = lnkb;
    next_lnkc = lnkc;
    if (CFG_WR) begin
      unique case (CFG_ADDR)
        PSM_REG_CTRL: next_ctrl = CFG_WDATA;
        PSM_REG_PER0: next_per0 = CFG_WDATA;
        PSM_REG_PER1: next_per1 = CFG_WDATA;
        PSM_REG_PER2: next_per2 = CFG_WDATA;
        PSM_REG_SBA: next_sba = CFG_WDATA;
        PSM_REG_SBB: next_sbb = CFG_WDATA;
        PSM_REG_LNKA: next_lnka = CFG_WDATA;
        PSM_REG_LNKB: next_lnkb = CFG_WDATA;
        PSM_REG_LNKC: next_lnkc = CFG_WDATA;
        default: ;
      endcase
    end
    next_rvalid = CFG_RD;
    next_rdata = CFG_RDATA;
    if (CFG_RD) begin
      unique case (CFG_ADDR)
        PSM_REG_CTRL: next_rdata = ctrl;
        PSM_REG_PER0: next_rdata = per0;
        PSM_REG_PER1: next_rdata = per1;
        PSM_REG_PER2: next_rdata = per2;
        PSM_REG_HOLD0: next_rdata = hold[7:0];
        PSM_REG_HOLD1: next_rdata = {3'h0, hold[12:8]};
        PSM_REG_SBA: next_rdata = sba;
        PSM_REG_SBB: next_rdata = sbb;
        PSM_REG_LNKA: next_rdata = lnka;
        PSM_REG_LNKB: next_rdata = lnkb;
        PSM_REG_LNKC: next_rdata = lnkc;
        default: next_rdata = PSM_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl <= PSM_RST_BYTE;
      per0 <= PSM_RST_BYTE;
      per1 <= PSM_RST_BYTE;
      per2 <= PSM_RST_BYTE;
      sba <= PSM_RST_BYTE;
      sbb <= PSM_RST_BYTE;
      lnka <= PSM_RST_BYTE;
      lnkb <= PSM_RST_BYTE;
      lnkc <= PSM_RST_BYTE;
      CFG_RDATA <= PSM_RST_BYTE;
      CFG_RVALID <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      per0 <= next_per0;
      per1 <= next_per1;
      per2 <= next_per2;
      sba <= next_sba;
      sbb <= next_sbb;
      lnka <= next_lnka;
      lnkb <= next_lnkb;
      lnkc <= next_lnkc;
      CFG_RDATA <= next_rdata;
      CFG_RVALID <= next_rvalid;
    end
  end

  // ****************************************
  // Peak detector
  // ****************************************
  logic enable, active, next_active;
  logic [23:0] timer, next_timer;
  logic [12:0] store, next_store, mag;
  logic transfer, next_strobe;

  assign enable = ctrl[PSM_CTRL_EN_BIT];
  assign mag = psm_abs(SAMPLE);
  assign transfer = active && SAMPLE_VALID && (timer <= PSM_CNT_ONE);

  always_comb begin
    next_active = active;
    next_timer = timer;
    next_store = store;
    next_hold = hold;
    next_strobe = 1'b0;
    if (!enable) begin
      next_active = 1'b0;
    end else if (SAMPLE_VALID) begin
      if (!active || transfer) begin
        // Transfer uses the old store so the next window starts clean
        if (transfer) begin
          next_hold = (mag > store) ? mag : store;
          next_strobe = 1'b1;
        end
        next_active = 1'b1;
        next_timer = window_length;
        next_store = mag;
      end else begin
        next_timer = timer - PSM_CNT_ONE;
        if (mag > store) begin
          next_store = mag;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      active <= 1'b0;
      timer <= '0;
      store <= '0;
      hold <= '0;
      PEAK_STROBE <= 1'b0;
    end else begin
      active <= next_active;
      timer <= next_timer;
      store <= next_store;
      hold <= next_hold;
      PEAK_STROBE <= next_strobe;
    end
  end

  assign PEAK_HOLD = hold;

  // ****************************************
  // Sideband serializer
  // ****************************************
  logic sb_en, busy, next_busy;
  logic [24:0] frame, next_frame;
  logic [2:0] sub_cnt, next_sub_cnt, bit_cnt, next_bit_cnt;
  logic [4:0] idle_sub;
  logic [1:0] cs;
  logic ctl_bit;
  logic [15:0] next_sample;
  logic next_svalid;

  assign sb_en = ((sba[1:0] & PSM_SBA_EN) == PSM_SBA_EN) && sbb[PSM_SBB_EN_BIT];
  assign cs = lnkc[1:0] & PSM_LNKC_CS_MASK;
  assign idle_sub = PSM_SUB_IDLE;

  always_comb begin
    next_busy = busy;
    next_frame = frame;
    next_sub_cnt = sub_cnt;
    next_bit_cnt = bit_cnt;
    ctl_bit = busy ? frame[24] : idle_sub[PSM_SUB_W - 1 - int'(bit_cnt)];
    if (!sb_en) begin
      next_busy = 1'b0;
      next_bit_cnt = '0;
      ctl_bit = 1'b0;
    end else if (SAMPLE_VALID) begin
      if (next_strobe) begin
        // Five subframes, each with start bit
        next_frame = {PSM_SUB_IDENT,
                      PSM_START_BIT, next_hold[12:9],
                      PSM_START_BIT, next_hold[8:5],
                      PSM_START_BIT, next_hold[4:1],
                      PSM_START_BIT, next_hold[0], 3'h0};
        next_busy = 1'b1;
        next_sub_cnt = '0;
        next_bit_cnt = '0;
      end else if (busy) begin
        next_frame = {frame[23:0], 1'b0};
        next_bit_cnt = (bit_cnt == PSM_BIT_CNT_LAST) ? 3'h0 : bit_cnt + 3'h1;
        if (bit_cnt == PSM_BIT_CNT_LAST) begin
          next_sub_cnt = sub_cnt + 3'h1;
          if (sub_cnt == PSM_FRAME_CNT_LAST) begin
            next_busy = 1'b0;
          end
        end
      end else begin
        next_bit_cnt = (bit_cnt == PSM_BIT_CNT_LAST) ? 3'h0 : bit_cnt + 3'h1;
      end
    end
    next_sample = SAMPLE;
    if (sb_en && cs != 2'h0) begin
      // Monitor bit always rides in the lowest of the cs top control slots
      next_sample[PSM_SMP_W - 1 - int'(cs) + 1] = ctl_bit;
    end
    next_svalid = SAMPLE_VALID;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      busy <= 1'b0;
      frame <= '0;
      sub_cnt <= '0;
      bit_cnt <= '0;
      LINK.sample <= '0;
      LINK.sample_valid <= 1'b0;
      LINK.cb_count <= '0;
    end else begin
      busy <= next_busy;
      frame <= next_frame;
      sub_cnt <= next_sub_cnt;
      bit_cnt <= next_bit_cnt;
      LINK.sample <= next_sample;
      LINK.sample_valid <= next_svalid;
      LINK.cb_count <= sb_en ? cs : 2'h0;
    end
  end
endmodule

/* File: hw/psm_receiver.sv */
`timescale 1ns/1ps
// Purpose: Link-side receiver that rebuilds peak frames from control bits
// Assumes: Device and receiver share CLK
// Notes: Hunts for identifier subframe, then checks every start bit
module psm_receiver
  import psm_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  psm_link_if.rcv LINK,
  output logic [12:0] PEAK,
  output logic PEAK_VALID,
  output logic FRAME_ERROR
);
  // ****************************************
  // Deserializer
  // ****************************************
  logic [24:0] shift, next_shift;
  logic [4:0] count, next_count;
  logic hunting, next_hunting;
  logic [12:0] next_peak;
  logic next_valid, next_error, bit_in;
  logic [24:0] cand;

  always_comb begin
    // Monitor slot is the lowest of the cb_count top bits, bit 16 minus cb_count
    // No slot when the sideband is off, so never index past the sample
    bit_in = 1'b0;
    if (LINK.cb_count != 2'h0) begin
      bit_in = LINK.sample[PSM_SMP_W - int'(LINK.cb_count)];
    end
    cand = {shift[23:0], bit_in};
    next_shift = shift;
    next_count = count;
    next_hunting = hunting;
    next_peak = PEAK;
    next_valid = 1'b0;
    next_error = 1'b0;
    if (LINK.sample_valid && LINK.cb_count != 2'h0) begin
      next_shift = cand;
      if (hunting) begin
        if (cand[4:0] == PSM_SUB_IDENT) begin
          next_hunting = 1'b0;
          next_count = 5'(PSM_SUB_W);
        end
      end else begin
        next_count = count + 5'd1;
        if (count == 5'(PSM_FRAME_W - 1)) begin
          next_hunting = 1'b1;
          next_count = '0;
          // A set data LSB before the tail zeros would otherwise fake an ident
          next_shift = '0;
          // Validate start bits before trusting data
          if (cand[19] && cand[14] && cand[9] && cand[4]) begin
            next_peak = {cand[18:15], cand[13:10], cand[8:5], cand[3]};
            next_valid = 1'b1;
          end else begin
            next_error = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      shift <= '0;
      count <= '0;
      hunting <= 1'b1;
      PEAK <= '0;
      PEAK_VALID <= 1'b0;
      FRAME_ERROR <= 1'b0;
    end else begin
      shift <= next_shift;
      count <= next_count;
      hunting <= next_hunting;
      PEAK <= next_peak;
      PEAK_VALID <= next_valid;
      FRAME_ERROR <= next_error;
    end
  end
endmodule

/* File: tb/psm_link_properties.sv */
// Purpose: Properties of the peak sideband on the link
// Assumes: One sideband slot, samples back to back while it is on
// Notes: PER must match the window length that the bench programs
`timescale 1ns/1ps
module psm_link_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [15:0] sample,
  input wire logic sample_valid,
  input wire logic [1:0] cb_count
);
  // ************************
  // Frame tracking
  // ************************
  localparam int PER = 30;
  logic sb;
  logic go;
  logic act;
  logic [4:0] pos;
  assign sb = sample[15];
  assign go = sample_valid && cb_count == 2'h1 && sb && !act;
  always_ff @(posedge CLK) begin
    if (RST || cb_count != 2'h1) begin
      act <= 1'b0;
      pos <= 5'h00;
    end else if (sample_valid && (go || act)) begin
      act <= go || pos != 5'h18;
      pos <= go ? 5'h01 : pos + 5'h01;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ************************
  // Properties
  // ************************
  a_reset_quiet: assert property (disable iff (1'b0) RST |=> !sample_valid && cb_count == 2'h0)
    else $error("link not quiet after reset");
  a_ident_zeros: assert property (act && sample_valid && pos inside {[5'h01:5'h04]} |-> !sb)
    else $error("identifier subframe not zero");
  a_start_bits: assert property (act && sample_valid && pos inside {5'h05, 5'h0a, 5'h0f, 5'h14} |-> sb)
    else $error("subframe start bit missing");
  a_tail_zeros: assert property (act && sample_valid && pos inside {[5'h16:5'h18]} |-> !sb)
    else $error("frame tail not zero");
  a_frame_span: assert property (go |-> ##5 sb ##5 sb ##5 sb ##5 sb)
    else $error("start bits not five apart");
  a_idle_gap: assert property (act && sample_valid && pos == 5'h18 |=> (!sb || !sample_valid) [*4])
    else $error("idle slots not zero");
  a_frame_period: assert property (go |-> ##PER (sb || !sample_valid || cb_count != 2'h1))
    else $error("frame period wrong");
  a_idle_before: assert property (go && $past(sample_valid) && $past(cb_count) == 2'h1 |-> !$past(sb))
    else $error("frame not preceded by idle");
  c_frame: cover property (go);
  c_frame_end: cover property (act && pos == 5'h18);
  c_three_slots: cover property (cb_count == 2'h3);
endmodule

/* File: tb/test_peak_signal_monitor.sv */
// Purpose: Self-checking bench for the peak monitor and its link receiver
// Assumes: Window 30 with sideband on, window 4 with gapped samples after
// Notes: Expected peaks come from a model of the driven samples
`timescale 1ns/1ps
module test_peak_signal_monitor
  import psm_pkg::*;
;
  localparam logic [15:0] CORNER [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0003};
  logic clk;
  logic rst;
  logic [15:0] sample;
  logic sample_valid;
  logic cfg_wr;
  logic cfg_rd;
  logic [11:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic [12:0] peak_hold;
  logic peak_strobe;
  logic [12:0] peak;
  logic peak_valid;
  logic frame_error;
  int n_errors;
  int cmp_count;
  int idx;
  int win;
  logic [12:0] run;
  logic [12:0] last;
  logic [12:0] exp_hold[$];
  logic [12:0] exp_rx[$];
  logic [7:0] rb[3];
  psm_link_if link();
  psm_monitor u_psm_monitor (.CLK(clk), .RST(rst), .SAMPLE(sample),
    .SAMPLE_VALID(sample_valid), .CFG_WR(cfg_wr), .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CFG_RVALID(cfg_rvalid),
    .PEAK_HOLD(peak_hold), .PEAK_STROBE(peak_strobe), .LINK(link));
  psm_receiver u_psm_receiver (.CLK(clk), .RST(rst), .LINK(link), .PEAK(peak),
    .PEAK_VALID(peak_valid), .FRAME_ERROR(frame_error));
  psm_link_properties u_psm_link_properties (.CLK(clk), .RST(rst), .sample(link.sample),
    .sample_valid(link.sample_valid), .cb_count(link.cb_count));
  // ************************
  // Checks and bus tasks
  // ************************
  task automatic chk_peak(input logic [12:0] got, input logic [12:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] mag(input logic [15:0] s);
    int a;
    a = (s[15] == 1'b1) ? 65536 - int'(s) : int'(s);
    return (a >= 16384) ? 13'h1fff : 13'(a >> 2);
  endfunction
  // A spare cycle after each access keeps strobes from being set twice in one step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clk);
    #1 cfg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge clk);
    #1 cfg_rd = 1'b0;
    chk_reg({7'h00, cfg_rvalid}, 8'h01);
    chk_reg(cfg_rdata, e);
    @(posedge clk);
    #1;
  endtask
  task automatic set_len(input int n);
    for (int i = 0; i < 3; i++) begin
      wr(12'(PSM_REG_PER0 + i), 8'(n >> (8 * i)));
    end
  endtask
  task automatic feed(input int n, input bit gaps);
    logic [15:0] s;
    logic v;
    for (int i = 0; i < n; i++) begin
      s = (i % 23 == 5) ? CORNER[(i / 23) % 4] : 16'($urandom);
      v = !gaps || ($urandom_range(3) != 0);
      sample = s;
      sample_valid = v;
      if (v) begin
        run = (idx == 0 || mag(s) > run) ? mag(s) : run;
        if (idx > 0 && idx % win == 0) begin
          exp_hold.push_back(run);
          if (!gaps) exp_rx.push_back(run);
          last = run;
          run = mag(s);
        end
        idx++;
      end
      @(posedge clk);
      #1;
    end
    sample_valid = 1'b0;
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ************************
  // Clock, watchdog, monitors, sequence
  // ************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
  always @(posedge clk) begin
    if (!rst && peak_strobe === 1'b1) begin
      chk_peak(peak_hold, exp_hold.size() ? exp_hold.pop_front() : ~peak_hold);
    end
    if (!rst && peak_valid === 1'b1) begin
      chk_peak(peak, exp_rx.size() ? exp_rx.pop_front() : ~peak);
    end
    if (!rst && frame_error !== 1'b0) begin
      chk_reg({7'h00, frame_error}, 8'h00);
    end
  end
  initial begin
    void'($urandom(19551));
    {rst, sample, sample_valid, cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {1'b1, 39'h0};
    {idx, win, run} = {32'h0, 32'd30, 13'h0};
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    rd(PSM_REG_HOLD0, 8'h00);
    rd(PSM_REG_HOLD1, 8'h00);
    rd(12'h276, 8'h00);
    foreach (rb[i]) begin
      rb[i] = 8'($urandom);
      wr(12'(PSM_REG_PER0 + i), rb[i]);
    end
    foreach (rb[i]) rd(12'(PSM_REG_PER0 + i), rb[i]);
    set_len(30);
    wr(PSM_REG_LNKA, 8'h5a);
    wr(PSM_REG_LNKB, 8'ha5);
    rd(PSM_REG_LNKA, 8'h5a);
    rd(PSM_REG_LNKB, 8'ha5);
    wr(PSM_REG_SBA, 8'h03);
    for (int i = 0; i < 4; i++) begin
      wr(PSM_REG_LNKC, 8'((i + 2) % 4));
      chk_reg({6'h00, link.cb_count}, 8'h00);
    end
    wr(PSM_REG_SBB, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(PSM_REG_LNKC, 8'((i + 2) % 4));
      chk_reg({6'h00, link.cb_count}, 8'((i + 2) % 4));
    end
    wr(PSM_REG_CTRL, 8'h02);
    feed(210, 1'b0);
    wr(PSM_REG_LNKC, 8'h03);
    feed(60, 1'b0);
    repeat (4) @(posedge clk);
    #1;
    rd(PSM_REG_HOLD0, last[7:0]);
    rd(PSM_REG_HOLD1, {3'h0, last[12:8]});
    chk_reg(8'(exp_rx.size()), 8'h00);
    wr(PSM_REG_LNKC, 8'h00);
    wr(PSM_REG_CTRL, 8'h00);
    set_len(4);
    {idx, win} = {32'h0, 32'd4};
    wr(PSM_REG_CTRL, 8'h02);
    feed(400, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    chk_reg(8'(exp_hold.size()), 8'h00);
    conclude();
  end
endmodule
